// ### verilog/adp_chain.sv
// Two-channel dynamic equalizer, compressor, limiter, volume and level meter.
`timescale 1ns/1ps
module adp_chain
	import adp_pkg::*;
(
	// Clock, reset and enable
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire logic               ce,
	// Audio in
	input  wire logic               in_valid,
	input  wire logic signed [31:0] in_left,
	input  wire logic signed [31:0] in_right,
	// Audio out
	output logic                    out_valid,
	output logic signed [31:0]      out_left,
	output logic signed [31:0]      out_right,
	// Coefficient page port
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	output logic [31:0]             reg_rdata
);
	logic signed [31:0] shadow [PAGE_WORDS];
	logic signed [31:0] active [PAGE_WORDS];
	logic signed [31:0] sn_e [2];
	logic signed [31:0] lim_e [2];
	logic signed [31:0] lim_g [2];
	logic signed [31:0] meter [2];
	logic signed [31:0] mix_r [2];
	logic signed [31:0] eq_lvl [2];
	logic signed [31:0] eq_y [2];
	logic signed [31:0] lo_y [2];
	logic signed [31:0] mtr_src [2];
	logic signed [31:0] fin_y [2];

	wire       step  = ce && in_valid;
	wire [5:0] widx  = reg_addr[7:2];
	wire       wr_ok = ce && reg_wr && WR_MASK[widx];

	wire signed [31:0] eq_alpha = active[W_EQ_ALPHA];
	wire signed [31:0] eq_gain  = active[W_EQ_GAIN];
	wire signed [31:0] eq_ofs   = active[W_EQ_OFS];
	wire signed [31:0] sn_scale = active[W_SN_SCALE];
	wire signed [31:0] lim_thr  = active[W_LIM_THR];
	wire signed [31:0] lim_atk  = active[W_LIM_ATK];
	wire signed [31:0] lim_rel  = active[W_LIM_REL];
	wire signed [31:0] soft_a   = active[W_SOFT_A];
	wire signed [31:0] soft_w   = active[W_SOFT_W];
	wire signed [31:0] fine_vol = active[W_FINE_VOL];
	wire signed [31:0] boost    = active[W_BOOST];
	wire signed [31:0] mtr_tc   = active[W_MTR_TC];
	wire               mtr_pre  = active[W_MTR_SEL][SEL_PRE];

	wire [31:0] rd_word = (widx == 6'(W_MTR_L)) ? meter[0] :
		(widx == 6'(W_MTR_R)) ? meter[1] : (WR_MASK[widx] ? shadow[widx] : ZERO);

	// Host writes land in the shadow page; the active page is what the datapath uses.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				shadow[i] <= ZERO;
			end
		end else if (wr_ok) begin
			shadow[widx] <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				active[i] <= ZERO;
			end
		end else if (step) begin
			active <= shadow;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= ZERO;
		end else if (ce && reg_rd) begin
			reg_rdata <= rd_word;
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_ch
		wire signed [31:0] x = (c == 0) ? in_left : in_right;
		wire signed [31:0] hi_y, sn_y, lp_y, hp_y;
		wire signed [31:0] bd_y [2];

		// Equalizer paths: high level, low level and sense.
		adp_biquad u_hi (.clock(clock), .resetn(resetn), .step(step), .x(x), .y(hi_y),
			.b0(active[W_EQ_HI+BQ_B0]), .b1(active[W_EQ_HI+BQ_B1]), .b2(active[W_EQ_HI+BQ_B2]),
			.a1(active[W_EQ_HI+BQ_A1]), .a2(active[W_EQ_HI+BQ_A2]));
		adp_biquad u_lo (.clock(clock), .resetn(resetn), .step(step), .x(x), .y(lo_y[c]),
			.b0(active[W_EQ_LO+BQ_B0]), .b1(active[W_EQ_LO+BQ_B1]), .b2(active[W_EQ_LO+BQ_B2]),
			.a1(active[W_EQ_LO+BQ_A1]), .a2(active[W_EQ_LO+BQ_A2]));
		adp_biquad u_sn (.clock(clock), .resetn(resetn), .step(step), .x(x), .y(sn_y),
			.b0(active[W_EQ_SN+BQ_B0]), .b1(active[W_EQ_SN+BQ_B1]), .b2(active[W_EQ_SN+BQ_B2]),
			.a1(active[W_EQ_SN+BQ_A1]), .a2(active[W_EQ_SN+BQ_A2]));

		// Sense scale is 8.24 so it can raise or lower the sensed level.
		wire signed [31:0] sn_s    = mulq(sn_y, sn_scale, Q24);
		wire signed [31:0] sn_sq   = mulq(sn_s, sn_s, Q31);
		wire signed [31:0] sn_next = sat32(66'(sn_e[c]) +
			66'(mulq(eq_alpha, sat32(66'(sn_sq) - 66'(sn_e[c])), Q31)));
		wire signed [31:0] knee    = sat32(66'(mulq(eq_lvl[c], eq_gain, Q31)) <<< KNEE_SHIFT);
		wire signed [31:0] hl_d    = sat32(66'(hi_y) - 66'(lo_y[c]));

		assign eq_lvl[c] = sat32(66'(sn_e[c]) + 66'(eq_ofs));
		assign mix_r[c]  = (knee < 0) ? ZERO : knee;
		assign eq_y[c]   = sat32(66'(lo_y[c]) + 66'(mulq(mix_r[c], hl_d, Q31)));

		// Band split for the two compressors.
		adp_biquad u_lp (.clock(clock), .resetn(resetn), .step(step), .x(eq_y[c]), .y(lp_y),
			.b0(active[W_XO_LP+BQ_B0]), .b1(active[W_XO_LP+BQ_B1]), .b2(active[W_XO_LP+BQ_B2]),
			.a1(active[W_XO_LP+BQ_A1]), .a2(active[W_XO_LP+BQ_A2]));
		adp_biquad u_hp (.clock(clock), .resetn(resetn), .step(step), .x(eq_y[c]), .y(hp_y),
			.b0(active[W_XO_HP+BQ_B0]), .b1(active[W_XO_HP+BQ_B1]), .b2(active[W_XO_HP+BQ_B2]),
			.a1(active[W_XO_HP+BQ_A1]), .a2(active[W_XO_HP+BQ_A2]));

		for (genvar b = 0; b < 2; b++) begin : g_band
			localparam int PB = W_BAND0 + b * BAND_WORDS;
			logic signed [31:0] be, bg;
			wire signed [31:0] bx  = (b == 0) ? lp_y : hp_y;
			wire signed [31:0] t1  = active[PB+RC_T1];
			wire signed [31:0] t2  = active[PB+RC_T2];
			wire               r0  = be < t1;
			wire               r2  = be >= t2;
			wire signed [31:0] kk  = r0 ? active[PB+RC_K0] : (r2 ? active[PB+RC_K2]
				: active[PB+RC_K1]);
			wire signed [31:0] th  = r2 ? t2 : t1;
			wire signed [31:0] sh  = r2 ? active[PB+RC_SHIFT2] : active[PB+RC_SHIFT1];
			wire signed [31:0] tg0 = sat32(66'(UNITY) + 66'(sh) +
				66'(mulq(kk, sat32(66'(be) - 66'(th)), Q31)));
			wire signed [31:0] tgt = (tg0 < 0) ? ZERO : tg0;
			wire signed [31:0] bsq = mulq(bx, bx, Q31);
			wire signed [31:0] rt  = (tgt < bg) ? active[PB+RC_ATTACK] : active[PB+RC_DECAY];
			wire signed [31:0] next_be = sat32(66'(be) + 66'(mulq(active[PB+RC_ENERGY],
				sat32(66'(bsq) - 66'(be)), Q31)));
			wire signed [31:0] next_bg = sat32(66'(bg) +
				66'(mulq(rt, sat32(66'(tgt) - 66'(bg)), Q31)));

			assign bd_y[b] = mulq(bx, bg, Q31);

			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					be <= ZERO;
					bg <= UNITY;
				end else if (step) begin
					be <= next_be;
					bg <= next_bg;
				end
			end
		end

		wire signed [31:0] drc_y  = sat32(66'(bd_y[0]) + 66'(bd_y[1]));
		// Limiter measures its own output energy, one sample behind.
		wire signed [31:0] lim_y  = mulq(drc_y, lim_g[c], Q31);
		wire signed [31:0] lim_sq = mulq(lim_y, lim_y, Q31);
		wire signed [31:0] next_le = sat32(66'(mulq(soft_w, lim_e[c], Q31)) +
			66'(mulq(soft_a, lim_sq, Q31)));
		wire signed [31:0] g_up   = sat32(66'(lim_g[c]) + 66'(lim_rel));
		wire signed [31:0] next_lg = (lim_e[c] > lim_thr) ?
			((lim_g[c] > lim_atk) ? lim_g[c] - lim_atk : ZERO) :
			((lim_e[c] < lim_thr) ? g_up : lim_g[c]);
		// Boost saturates at full scale, then fine volume brings the clipped wave down.
		wire signed [31:0] bst_y  = mulq(lim_y, boost, Q30);
		wire signed [31:0] m_sq;
		wire signed [31:0] next_me;

		assign fin_y[c]   = mulq(bst_y, fine_vol, Q30);
		assign mtr_src[c] = mtr_pre ? x : fin_y[c];
		assign m_sq       = mulq(mtr_src[c], mtr_src[c], Q31);
		assign next_me    = sat32(66'(meter[c]) +
			66'(mulq(mtr_tc, sat32(66'(m_sq) - 66'(meter[c])), Q31)));

		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				sn_e[c]  <= ZERO;
				lim_e[c] <= ZERO;
				lim_g[c] <= UNITY;
				meter[c] <= ZERO;
			end else if (step) begin
				sn_e[c]  <= sn_next;
				lim_e[c] <= next_le;
				lim_g[c] <= next_lg;
				meter[c] <= next_me;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_left  <= ZERO;
			out_right <= ZERO;
		end else if (ce) begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_left  <= fin_y[0];
				out_right <= fin_y[1];
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_coef_hold;
		!step |=> $stable(eq_alpha) && $stable(eq_gain);
	endproperty
	a_coef_hold: assert property (p_coef_hold) else $error("active coefficient moved mid-sample");

	property p_coef_load;
		step |=> eq_ofs == $past(shadow[W_EQ_OFS]);
	endproperty
	a_coef_load: assert property (p_coef_load) else $error("offset word not taken at sample");

	property p_ratio_floor;
		eq_lvl[0] <= 0 |-> mix_r[0] == ZERO;
	endproperty
	a_ratio_floor: assert property (p_ratio_floor) else $error("ratio not zero below knee");

	property p_mix_low;
		mix_r[0] == ZERO |-> eq_y[0] == lo_y[0];
	endproperty
	a_mix_low: assert property (p_mix_low) else $error("zero ratio must pass low path");

	property p_sense_freeze;
		step && eq_alpha == ZERO |=> sn_e[0] == $past(sn_e[0]);
	endproperty
	a_sense_freeze: assert property (p_sense_freeze) else $error("zero alpha moved energy");

	property p_lim_engage;
		step && lim_e[0] > lim_thr && lim_g[0] > lim_atk
			|=> lim_g[0] == $past(lim_g[0]) - $past(lim_atk);
	endproperty
	a_lim_engage: assert property (p_lim_engage) else $error("limiter did not engage");

	property p_lim_release;
		step && lim_e[0] < lim_thr && 66'(lim_g[0]) + 66'(lim_rel) < 66'(UNITY)
			|=> lim_g[0] == $past(lim_g[0]) + $past(lim_rel);
	endproperty
	a_lim_release: assert property (p_lim_release) else $error("limiter did not release");

	property p_lim_hold;
		step && lim_e[0] == lim_thr |=> $stable(lim_g[0]);
	endproperty
	a_lim_hold: assert property (p_lim_hold) else $error("limiter gain moved at threshold");

	property p_meter_src;
		mtr_pre |-> mtr_src[0] == in_left;
	endproperty
	a_meter_src: assert property (p_meter_src) else $error("meter not on input audio");

	property p_meter_read;
		ce && reg_rd && widx == 6'(W_MTR_R) |=> reg_rdata == $past(meter[1]);
	endproperty
	a_meter_read: assert property (p_meter_read) else $error("meter word read wrong");

	property p_vol_zero;
		step && fine_vol == ZERO |=> out_valid && out_left == ZERO && out_right == ZERO;
	endproperty
	a_vol_zero: assert property (p_vol_zero) else $error("zero volume not silent");

	property p_cov_engage;
		step && lim_e[0] > lim_thr;
	endproperty
	c_cov_engage: cover property (p_cov_engage);

	property p_cov_blend;
		mix_r[0] > 0 && mix_r[0] < UNITY;
	endproperty
	c_cov_blend: cover property (p_cov_blend);

	property p_cov_load;
		wr_ok ##1 step;
	endproperty
	c_cov_load: cover property (p_cov_load);
endmodule

// ### pkg/adp_pkg.sv
// Shared constants, coefficient page layout and fixed-point helpers for the dynamics chain.
package adp_pkg;
	localparam int              PAGE_WORDS = 64;
	localparam logic [31:0]     ZERO       = 32'h00000000;
	localparam logic [31:0]     UNITY      = 32'h7FFFFFFF;
	localparam int              Q31        = 31;
	localparam int              Q30        = 30;
	localparam int              Q24        = 24;
	localparam int              KNEE_SHIFT = 5;
	localparam int              SEL_PRE    = 0;
	// Word indexes in the coefficient page; byte address is four times the index.
	localparam int              W_EQ_HI    = 0;
	localparam int              W_EQ_LO    = 5;
	localparam int              W_EQ_SN    = 10;
	localparam int              W_SN_SCALE = 15;
	localparam int              W_MTR_TC   = 16;
	localparam int              W_EQ_ALPHA = 8'h44 / 4;
	localparam int              W_EQ_GAIN  = 8'h48 / 4;
	localparam int              W_EQ_OFS   = 8'h4C / 4;
	localparam int              W_FINE_VOL = 20;
	localparam int              W_BOOST    = 21;
	localparam int              W_LIM_THR  = 22;
	localparam int              W_SOFT_A   = 23;
	localparam int              W_SOFT_W   = 24;
	localparam int              W_LIM_ATK  = 25;
	localparam int              W_LIM_REL  = 26;
	localparam int              W_MTR_SEL  = 8'h70 / 4;
	localparam int              W_MTR_L    = 29;
	localparam int              W_MTR_R    = 30;
	localparam int              W_XO_LP    = 32;
	localparam int              W_XO_HP    = 37;
	localparam int              W_BAND0    = 42;
	localparam int              BAND_WORDS = 10;
	// Writable words: spare and meter words are excluded.
	localparam logic [63:0]     WR_MASK    = 64'h3FFFFFFF17FFFFFF;
	// Biquad coefficient order within a section.
	localparam int              BQ_B0      = 0;
	localparam int              BQ_B1      = 1;
	localparam int              BQ_B2      = 2;
	localparam int              BQ_A1      = 3;
	localparam int              BQ_A2      = 4;
	// Compressor band word order.
	localparam int              RC_K0      = 0;
	localparam int              RC_K1      = 1;
	localparam int              RC_K2      = 2;
	localparam int              RC_T1      = 3;
	localparam int              RC_T2      = 4;
	localparam int              RC_SHIFT1  = 5;
	localparam int              RC_SHIFT2  = 6;
	localparam int              RC_ENERGY  = 7;
	localparam int              RC_ATTACK  = 8;
	localparam int              RC_DECAY   = 9;

	function automatic logic signed [31:0] sat32(input logic signed [65:0] v);
		if (v > 66'sh00000007FFFFFFF) begin
			sat32 = 32'sh7FFFFFFF;
		end else if (v < -66'sh000000080000000) begin
			sat32 = 32'sh80000000;
		end else begin
			sat32 = v[31:0];
		end
	endfunction

	function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
		input logic signed [31:0] b, input int sh);
		logic signed [63:0] p;
		p = a * b;
		mulq = sat32(66'(p >>> sh));
	endfunction
endpackage

// ### verilog/adp_biquad.sv
// Direct form 1 biquad section with 1.31 coefficients.
`timescale 1ns/1ps
module adp_biquad
	import adp_pkg::*;
(
	// Clock and control
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire logic               step,
	// Coefficients, b1 and a1 stored at half value
	input  wire logic signed [31:0] b0,
	input  wire logic signed [31:0] b1,
	input  wire logic signed [31:0] b2,
	input  wire logic signed [31:0] a1,
	input  wire logic signed [31:0] a2,
	// Samples
	input  wire logic signed [31:0] x,
	output logic signed [31:0]      y
);
	logic signed [31:0] x1, x2, y1, y2;
	wire signed [63:0]  p0 = b0 * x;
	wire signed [63:0]  p1 = b1 * x1;
	wire signed [63:0]  p2 = b2 * x2;
	wire signed [63:0]  p3 = a1 * y1;
	wire signed [63:0]  p4 = a2 * y2;
	wire signed [65:0]  acc = 66'(p0) + (66'(p1) <<< 1) + 66'(p2) + (66'(p3) <<< 1) + 66'(p4);

	assign y = sat32(acc >>> Q31);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			x1 <= ZERO;
			x2 <= ZERO;
			y1 <= ZERO;
			y2 <= ZERO;
		end else if (step) begin
			x1 <= x;
			x2 <= x1;
			y1 <= y;
			y2 <= y1;
		end
	end
endmodule

// ### testbench/adp_source.sv
// Sample source standing in for the upstream audio stages.
`timescale 1ns/1ps
module adp_source
	import adp_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Request from the bench
	input  wire logic               send,
	input  wire logic signed [31:0] left_val,
	input  wire logic signed [31:0] right_val,
	// Audio toward the chain
	output logic                    in_valid,
	output logic signed [31:0]      in_left,
	output logic signed [31:0]      in_right
);
	// Between strobes the data lines flip, so a stale sample can never pass for a fresh one.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			in_valid <= 1'b0;
			in_left  <= ZERO;
			in_right <= ZERO;
		end else if (send) begin
			in_valid <= 1'b1;
			in_left  <= left_val;
			in_right <= right_val;
		end else begin
			in_valid <= 1'b0;
			in_left  <= ~in_left;
			in_right <= ~in_right;
		end
	end
endmodule

// ### testbench/adp_chain_tb.sv
// Self-checking bench for the two-channel dynamics chain.
`timescale 1ns/1ps
module adp_chain_tb
	import adp_pkg::*;
;
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [31:0] x;
		logic [31:0] y;
	} adp_row_s;
	localparam int             TOL       = 4096;
	logic                      clock     = 1'b0;
	logic                      resetn    = 1'b0;
	logic                      ce        = 1'b1;
	logic                      send      = 1'b0;
	logic signed [31:0]        left_val  = '0;
	logic signed [31:0]        right_val = '0;
	logic                      reg_wr    = 1'b0;
	logic                      reg_rd    = 1'b0;
	logic [7:0]                reg_addr  = '0;
	logic [31:0]               reg_wdata = '0;
	logic                      in_valid;
	logic signed [31:0]        in_left;
	logic signed [31:0]        in_right;
	logic                      out_valid;
	logic signed [31:0]        out_left;
	logic signed [31:0]        out_right;
	logic [31:0]               reg_rdata;
	logic [31:0]               rd_val;
	logic signed [31:0]        prev;
	int                        errors    = 0;
	int                        n_checks  = 0;
	int                        cnt;
	adp_row_s                  rows [19];

	always #4 clock = ~clock;

	adp_source i_adp_source (.clock(clock), .resetn(resetn), .send(send), .left_val(left_val),
		.right_val(right_val), .in_valid(in_valid), .in_left(in_left), .in_right(in_right));
	adp_chain i_adp_chain (.clock(clock), .resetn(resetn), .ce(ce), .in_valid(in_valid),
		.in_left(in_left), .in_right(in_right), .out_valid(out_valid), .out_left(out_left),
		.out_right(out_right), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic inr(input string what, input longint lo, input longint hi,
		input logic [31:0] got);
		longint v;
		v = longint'($signed(got));
		n_checks++;
		if ((^got === 1'bx) || v < lo || v > hi) begin
			errors++;
			$display("unexpected %s: expected %0d..%0d seen %h", what, lo, hi, got);
		end
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
		input int tol);
		inr(what, longint'($signed(exp)) - tol, longint'($signed(exp)) + tol, got);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		@(posedge clock);
		#1;
		d = reg_rdata;
	endtask

	// Sends one stereo sample and waits, bounded, for its result strobe.
	task automatic smp(input logic [31:0] l, input logic [31:0] r);
		int k;
		@(posedge clock);
		send      <= 1'b1;
		left_val  <= l;
		right_val <= r;
		@(posedge clock);
		send      <= 1'b0;
		for (k = 0; k < 4 && out_valid !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		if (out_valid !== 1'b1) begin
			errors++;
			$display("unexpected out_valid: expected 1 seen %b", out_valid);
			finish_test();
		end
	endtask

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		// Each row programs one word, then the third sample must show its effect.
		rows = '{
			'{8'h50, 32'h40000000, 32'h40000000, 32'h00000000},
			'{8'h54, 32'h40000000, 32'h40000000, 32'h00000000},
			'{8'h80, 32'h7FFFFFFF, 32'h40000000, 32'h00000000},
			'{8'h14, 32'h20000000, 32'h40000000, 32'h10000000},
			'{8'h00, 32'h7FFFFFFF, 32'h40000000, 32'h10000000},
			'{8'h4C, 32'h7FFFFFFF, 32'h40000000, 32'h10000000},
			'{8'h48, 32'h7FFFFFFF, 32'h40000000, 32'h40000000},
			'{8'h48, 32'h01000000, 32'h40000000, 32'h1C000000},
			'{8'h4C, 32'h00000000, 32'h40000000, 32'h10000000},
			'{8'h48, 32'h7FFFFFFF, 32'h40000000, 32'h10000000},
			'{8'h28, 32'h7FFFFFFF, 32'h40000000, 32'h10000000},
			'{8'h3C, 32'h01000000, 32'h40000000, 32'h10000000},
			'{8'h44, 32'h7FFFFFFF, 32'h0CCCCCCD, 32'h0645A1CA},
			'{8'h3C, 32'h02000000, 32'h06666666, 32'h0322D0E5},
			'{8'h48, 32'h00000000, 32'h40000000, 32'h10000000},
			'{8'h14, 32'h7FFFFFFF, 32'h60000000, 32'h60000000},
			'{8'h54, 32'h7FFFFFFF, 32'h60000000, 32'h7FFFFFFF},
			'{8'h50, 32'h20000000, 32'hA0000000, 32'hC0000000},
			'{8'h94, 32'h7FFFFFFF, 32'h10000000, 32'h20000000}
		};
		repeat (3) @(posedge clock);
		#1;
		check("reset out_valid", 32'h0, out_valid, 0);
		check("reset rdata", 32'h0, reg_rdata, 0);
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h44, rd_val);
		check("page reset", 32'h0, rd_val, 0);
		endt("reset");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			rd(rows[i].addr, rd_val);
			check("readback", rows[i].data, rd_val, 0);
			repeat (3) smp(rows[i].x, -rows[i].x);
			check("out_left", rows[i].y, out_left, TOL);
			check("out_right", -rows[i].y, out_right, TOL);
		end
		endt("rows");
		wr(8'h5C, 32'h7FFFFFFF);
		wr(8'h64, 32'h08000000);
		wr(8'h68, 32'h04000000);
		wr(8'h58, 32'h00000001);
		for (int i = 0; i < 8; i++) begin
			prev = out_left;
			smp(32'h10000000, 32'hF0000000);
			inr("limiter attack", 0, prev, out_left);
		end
		inr("limiter depth", 0, 32'h18000000, out_left);
		wr(8'h58, 32'h7FFFFFFF);
		// The raised threshold lands one sample late, so the gain steps down once more and the next two outputs do not rise.
		for (int i = 0; i < 2; i++) begin
			prev = out_left;
			smp(32'h10000000, 32'hF0000000);
			inr("limiter late attack", 0, prev, out_left);
		end
		for (int i = 0; i < 24; i++) begin
			prev = out_left;
			smp(32'h10000000, 32'hF0000000);
			inr("limiter release", prev, 32'h7FFFFFFF, out_left);
		end
		check("limiter recovered", 32'h20000000, out_left, TOL);
		endt("limiter");
		// Energy stays at zero, so the low band sits in its upper region and takes its shift.
		wr(8'hC0, 32'hC0000000);
		wr(8'hC8, 32'h7FFFFFFF);
		repeat (3) smp(32'h10000000, 32'hF0000000);
		check("band shift", 32'h18000000, out_left, TOL);
		wr(8'hC0, 32'h00000000);
		wr(8'hCC, 32'h7FFFFFFF);
		repeat (3) smp(32'h10000000, 32'hF0000000);
		check("band decay", 32'h20000000, out_left, TOL);
		endt("compressor");
		wr(8'h40, 32'h7FFFFFFF);
		wr(8'h70, 32'h00000001);
		rd(8'h70, rd_val);
		check("source select", 32'h00000001, rd_val, 0);
		repeat (3) smp(32'h40000000, 32'hC0000000);
		rd(8'h74, rd_val);
		check("left meter", 32'h20000000, rd_val, TOL);
		rd(8'h78, rd_val);
		check("right meter", 32'h20000000, rd_val, TOL);
		wr(8'h70, 32'h0);
		wr(8'h50, 32'h0);
		wr(8'h74, 32'h55555555);
		repeat (3) smp(32'h40000000, 32'hC0000000);
		rd(8'h74, rd_val);
		check("processed meter", 32'h0, rd_val, TOL);
		wr(8'h6C, 32'h12345678);
		rd(8'h6C, rd_val);
		check("unmapped word", 32'h0, rd_val, 0);
		endt("meter");
		@(posedge clock);
		ce <= 1'b0;
		wr(8'h44, 32'h0);
		cnt = 0;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			send <= (i < 1);
			#1;
			if (out_valid !== 1'b0) cnt++;
		end
		check("frozen strobes", 32'h0, cnt, 0);
		@(posedge clock);
		ce <= 1'b1;
		rd(8'h44, rd_val);
		check("frozen page", 32'h7FFFFFFF, rd_val, 0);
		cnt = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			send     <= (i < 4);
			left_val <= 32'h10000000;
			#1;
			if (out_valid === 1'b1) cnt++;
		end
		check("burst strobes", 32'h4, cnt, 0);
		endt("enable and burst");
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		#1;
		check("reset out_left", 32'h0, out_left, 0);
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h48, rd_val);
		check("page after reset", 32'h0, rd_val, 0);
		endt("second reset");
		finish_test();
	end
endmodule
